// ### verilog/chip_reset_and_boot_latch.v
`include "chip_reset_regs.vh"
`default_nettype none
module chip_reset_and_boot_latch (
  input wire mclk_i,
  input wire rst_n_i,
  input wire por_n_i,
  input wire warm_n_i,
  input wire emu_rst_i,
  input wire wdog_rst_i,
  input wire [`BOOT_W-1:0] boot_pins_i,
  input wire [`ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output reg emu_rst_o,
  output reg sys_rst_o,
  output wire [`NUM_MOD-1:0] mod_rst_o,
  output reg cpu_core_rst_o,
  output reg cpu_clk_en_o,
  output reg cpu_mem_host_en_o,
  output reg [31:0] pin_sel_a_o,
  output reg [31:0] pin_sel_b_o,
  output reg [`BOOT_W-1:0] boot_cfg_o
);
  ////////////////////////////////////////////////////////////////////////
  reg [31:0] pin_select_reg_a_reg;
  reg [31:0] pin_select_reg_b_reg;
  reg [1:0] next_state_reg;
  reg cpu_hold_reset_bit_reg;
  reg [`NUM_MOD-1:0] mod_rst_sw_reg;
  reg [`BOOT_W-1:0] boot_config_capture_reg;
  reg [31:0] rdata_next;
  wire pin_rst;
  wire any_rst;
  wire [`NUM_MOD-1:0] mod_req;
  wire cpu_mod_rst;

  // reset-state decode, used for status and outputs
  function is_mod_rst;
    input [1:0] st;
    begin
      is_mod_rst = (st == `ST_CLK_OFF_RST) || (st == `ST_CLK_RST);
    end
  endfunction

  assign pin_rst = !por_n_i || !warm_n_i;
  assign any_rst = pin_rst || emu_rst_i || wdog_rst_i;
  assign cpu_mod_rst = is_mod_rst(next_state_reg);

  genvar g;
  generate
    for (g = 0; g < `NUM_MOD; g = g + 1) begin : g_mod
      if (g == `CPU_MOD) begin : g_cpu
        assign mod_req[g] = any_rst || mod_rst_sw_reg[g] || cpu_mod_rst;
      end else begin : g_oth
        assign mod_req[g] = any_rst || mod_rst_sw_reg[g];
      end
    end
  endgenerate

  reset_sync_cnt u_mod (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .mod_rst_req_i(mod_req),
    .mod_rst_o(mod_rst_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // software registers, loaded with their reset values by any chip-wide reset
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_select_reg_a_reg <= 32'h0000_0000;
      pin_select_reg_b_reg <= 32'h0000_0000;
      next_state_reg <= `ST_ENABLE;
      cpu_hold_reset_bit_reg <= 1'b1;
      mod_rst_sw_reg <= {`NUM_MOD{1'b0}};
    end else if (any_rst) begin
      pin_select_reg_a_reg <= 32'h0000_0000;
      pin_select_reg_b_reg <= 32'h0000_0000;
      next_state_reg <= `ST_ENABLE;
      cpu_hold_reset_bit_reg <= 1'b1;
      mod_rst_sw_reg <= {`NUM_MOD{1'b0}};
    end else if (wr_i) begin
      case (addr_i)
        `OFS_PIN_SEL_A: pin_select_reg_a_reg <= wdata_i;
        `OFS_PIN_SEL_B: pin_select_reg_b_reg <= wdata_i;
        `OFS_CPU_MOD_CTL: begin
          next_state_reg <= wdata_i[`CTL_NEXT_LSB+1:`CTL_NEXT_LSB];
          cpu_hold_reset_bit_reg <= wdata_i[`CTL_HOLD_BIT];
        end
        `OFS_MOD_RST: mod_rst_sw_reg <= wdata_i[`NUM_MOD-1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boot capture follows pins during a pin reset, last value kept at release
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      boot_config_capture_reg <= {`BOOT_W{1'b0}};
    end else begin
      if (pin_rst) begin
        boot_config_capture_reg <= boot_pins_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    rdata_next = 32'h0000_0000;
    case (addr_i)
      `OFS_BOOT_CFG: rdata_next[`BOOT_W-1:0] = boot_config_capture_reg;
      `OFS_PIN_SEL_A: rdata_next = pin_select_reg_a_reg;
      `OFS_PIN_SEL_B: rdata_next = pin_select_reg_b_reg;
      `OFS_CPU_MOD_CTL: begin
        rdata_next[`CTL_NEXT_LSB+1:`CTL_NEXT_LSB] = next_state_reg;
        rdata_next[`CTL_HOLD_BIT] = cpu_hold_reset_bit_reg;
      end
      `OFS_MOD_RST: rdata_next[`NUM_MOD-1:0] = mod_rst_sw_reg;
      `OFS_STATUS: rdata_next[`NUM_MOD-1:0] = mod_rst_o;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
      emu_rst_o <= 1'b1;
      sys_rst_o <= 1'b1;
      cpu_core_rst_o <= 1'b1;
      cpu_clk_en_o <= 1'b0;
      cpu_mem_host_en_o <= 1'b0;
      pin_sel_a_o <= 32'h0000_0000;
      pin_sel_b_o <= 32'h0000_0000;
      boot_cfg_o <= {`BOOT_W{1'b0}};
    end else begin
      rdata_o <= rd_i ? rdata_next : 32'h0000_0000;
      emu_rst_o <= !por_n_i;
      sys_rst_o <= any_rst;
      // core reset: module reset wins over hold bit
      cpu_core_rst_o <= any_rst || cpu_mod_rst || !cpu_hold_reset_bit_reg;
      cpu_clk_en_o <= !any_rst && (next_state_reg == `ST_CLK_RST ||
                                   next_state_reg == `ST_ENABLE);
      // memories reachable in local reset, only core held
      cpu_mem_host_en_o <= !any_rst && !cpu_hold_reset_bit_reg && !cpu_mod_rst;
      pin_sel_a_o <= pin_select_reg_a_reg;
      pin_sel_b_o <= pin_select_reg_b_reg;
      boot_cfg_o <= boot_config_capture_reg;
    end
  end
endmodule // chip_reset_and_boot_latch
`default_nettype wire

// ### include/chip_reset_regs.vh
// Functional notes
// - power-on pin low resets everything incl. memories, emulation; latches boot pins.
// - emulator or watchdog reset acts as warm reset without relatching boot pins.
// - module reset from software resets only the selected module.
// - cpu local reset resets only the core; memories keep contents.
// - during local reset the cpu memories stay reachable by the host.
// - clocked-reset and clock-off-reset states assert cpu module reset, overriding local.
// - power-on or warm reset captures boot settings into readable register.
// - pin selection follows latched pins plus two select registers, unchecked.
// - writing zero to hold bit asserts local reset; one releases it.
// - next-state zero is clock-off-reset: module reset on, module clock off.
// - next-state one is clocked-reset: module reset on, module clock running.
`ifndef CHIP_RESET_REGS_VH
`define CHIP_RESET_REGS_VH
`define ADDR_W 4
`define OFS_BOOT_CFG 4'h0
`define OFS_PIN_SEL_A 4'h1
`define OFS_PIN_SEL_B 4'h2
`define OFS_CPU_MOD_CTL 4'h3
`define OFS_MOD_RST 4'h4
`define OFS_STATUS 4'h5
`define CTL_NEXT_LSB 0
`define CTL_HOLD_BIT 8
`define ST_CLK_OFF_RST 2'h0
`define ST_CLK_RST 2'h1
`define ST_DISABLE 2'h2
`define ST_ENABLE 2'h3
`define CTL_RESET 32'h0000_0103
`define NUM_MOD 8
`define CPU_MOD 0
`define BOOT_W 16
`endif

// ### verilog/reset_sync_cnt.v
`include "chip_reset_regs.vh"
`default_nettype none
module reset_sync_cnt (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [`NUM_MOD-1:0] mod_rst_req_i,
  output reg [`NUM_MOD-1:0] mod_rst_o
);
  // registers each module reset one cycle, asserted under global reset
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mod_rst_o <= {`NUM_MOD{1'b1}};
    end else begin
      mod_rst_o <= mod_rst_req_i;
    end
  end
endmodule // reset_sync_cnt
`default_nettype wire

// ### bench/chip_reset_checker.sv
`include "chip_reset_regs.vh"
`default_nettype none
module chip_reset_checker (
  input wire logic mclk_i, rst_n_i, por_n_i, warm_n_i, emu_rst_i, wdog_rst_i, wr_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic emu_rst_o, sys_rst_o, cpu_core_rst_o, cpu_clk_en_o, cpu_mem_host_en_o,
  input wire logic [`NUM_MOD-1:0] mod_rst_o,
  input wire logic [`BOOT_W-1:0] boot_cfg_o
);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire quiet = por_n_i && warm_n_i && !emu_rst_i && !wdog_rst_i;
  wire ctl_wr = wr_i && quiet && addr_i == `OFS_CPU_MOD_CTL;
  a_por_emu: assert property (!por_n_i |=> emu_rst_o) else $error("emu reset missing");
  a_warm_emu: assert property (por_n_i |=> !emu_rst_o) else $error("emu reset stray");
  a_max_sys: assert property (emu_rst_i || wdog_rst_i |=> sys_rst_o) else $error("no sys");
  a_boot_keep: assert property (por_n_i && warm_n_i && $past(por_n_i) && $past(warm_n_i)
    |=> $stable(boot_cfg_o)) else $error("boot changed");
  a_hold_core: assert property (ctl_wr && !wdata_i[`CTL_HOLD_BIT] |-> ##2 cpu_core_rst_o)
    else $error("core not held");
  a_clk_off: assert property (ctl_wr && wdata_i[1:0] == `ST_CLK_OFF_RST
    |-> ##[2:3] !cpu_clk_en_o) else $error("clock runs");
  a_clk_run: assert property (ctl_wr && wdata_i[1:0] == `ST_CLK_RST
    |-> ##[2:3] cpu_clk_en_o) else $error("clock stopped");
  a_mod_state: assert property (ctl_wr && !wdata_i[1] |-> ##[2:4] mod_rst_o[`CPU_MOD])
    else $error("module reset missing");
  a_mem_core: assert property (cpu_mem_host_en_o |-> cpu_core_rst_o) else $error("mem open");
  c_ctl: cover property (ctl_wr);
  c_por: cover property (!por_n_i);
  c_mem: cover property (cpu_mem_host_en_o);
endmodule // chip_reset_checker
bind chip_reset_and_boot_latch chip_reset_checker chk (.*);
`default_nettype wire

// ### bench/board_model.sv
`default_nettype none
module board_model (
  input wire logic mclk_i,
  input wire logic [2:0] kind_i,
  input wire logic [15:0] pins_i,
  output logic por_n_i, warm_n_i, emu_rst_i, wdog_rst_i,
  output logic [15:0] boot_pins_i
);
  timeunit 1ns; timeprecision 1ns;
  // one reset source at a time, pins held steady
  always_ff @(posedge mclk_i) begin
    por_n_i <= kind_i != 3'h1;
    warm_n_i <= kind_i != 3'h2;
    emu_rst_i <= kind_i == 3'h3;
    wdog_rst_i <= kind_i == 3'h4;
    boot_pins_i <= pins_i;
  end
endmodule // board_model
`default_nettype wire

// ### bench/tb.sv
`include "chip_reset_regs.vh"
`default_nettype none
module tb;
  timeunit 1ns; timeprecision 1ns;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [2:0] kind_i = 3'h0;
  logic [15:0] pins_i = 16'h0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  wire logic por_n_i, warm_n_i, emu_rst_i, wdog_rst_i, emu_rst_o, sys_rst_o;
  wire logic cpu_core_rst_o, cpu_clk_en_o, cpu_mem_host_en_o;
  wire logic [15:0] boot_pins_i, boot_cfg_o;
  wire logic [31:0] rdata_o, pin_sel_a_o, pin_sel_b_o;
  wire logic [7:0] mod_rst_o;
  int mismatches = 0, num_checks = 0;
  board_model board (.*);
  chip_reset_and_boot_latch DUT (.*);
  always #10 mclk_i = ~mclk_i;
  task chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(logic [3:0] a, logic [31:0] d);
    @(posedge mclk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge mclk_i) wr_i <= 1'b0;
  endtask
  task rd(logic [3:0] a, logic [31:0] e);
    @(posedge mclk_i) {rd_i, addr_i} <= {1'b1, a};
    @(posedge mclk_i) rd_i <= 1'b0;
    #1 chk("rdata", e, rdata_o);
  endtask
  task idle(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  task s_local;
    wr(`OFS_CPU_MOD_CTL, 32'h3);
    idle(4);
    chk("core", 1, cpu_core_rst_o);
    chk("memen", 1, cpu_mem_host_en_o);
    chk("mod0", 0, mod_rst_o[0]);
    wr(`OFS_CPU_MOD_CTL, 32'h103);
    idle(4);
    chk("core", 0, cpu_core_rst_o);
  endtask
  task s_states;
    for (int n = 0; n < 4; n++) begin
      wr(`OFS_CPU_MOD_CTL, 32'h100 | n);
      idle(4);
      chk("mod0", n < 2, mod_rst_o[0]);
      chk("clken", n[0], cpu_clk_en_o);
    end
    wr(`OFS_CPU_MOD_CTL, 32'h1);
    idle(4);
    chk("memen", 0, cpu_mem_host_en_o);
    wr(`OFS_CPU_MOD_CTL, 32'h103);
  endtask
  task s_regs;
    wr(`OFS_PIN_SEL_A, 32'h5a5a0f0f);
    wr(`OFS_PIN_SEL_B, 32'h0ff0);
    wr(`OFS_MOD_RST, 32'h4);
    idle(4);
    chk("sela", 32'h5a5a0f0f, pin_sel_a_o);
    chk("selb", 32'h0ff0, pin_sel_b_o);
    chk("mods", 32'h4, mod_rst_o);
    rd(`OFS_STATUS, 32'h4);
    rd(4'hf, 32'h0);
    wr(`OFS_MOD_RST, 32'h0);
  endtask
  task s_pins;
    for (int k = 1; k < 5; k++) begin
      wr(`OFS_CPU_MOD_CTL, 32'h0);
      @(posedge mclk_i) {kind_i, pins_i} <= {k[2:0], 16'ha500 + k[15:0]};
      idle(3);
      chk("sys", 1, sys_rst_o);
      chk("emu", k == 1, emu_rst_o);
      @(posedge mclk_i) kind_i <= 3'h0;
      idle(4);
      chk("boot", k < 3 ? 16'ha500 + k : 16'ha502, boot_cfg_o);
      rd(`OFS_BOOT_CFG, k < 3 ? 16'ha500 + k : 16'ha502);
      rd(`OFS_CPU_MOD_CTL, `CTL_RESET);
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    s_local;
    s_states;
    s_regs;
    s_pins;
    stop_test;
  end
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule // tb
`default_nettype wire
